// [verilog/spi_master_transfer_regs.vh]
// Constants for the command-driven SPI master transfer block
// Operation
// (RL1) Host sets word count to byte count halved, rounded up, padding odd packets.
// (RL2) Auto select drives select low through the transfer, high afterwards.
// (RL3) Skip direction setup leaves all four line directions untouched.
// (RL4) Otherwise select, clock, output line become outputs, input line an input.
// (RL5) Serial clock near 1000000/(10+10*(256-divisor)) Hz; divisor 0 means 256.
// (RL6) Three-bit field gives bits in last byte; zero means eight.
// (RL7) Partial last byte sends top bits, returns received bits in top positions.
// (RL8) Each of the four signals maps to a digital line indexed 0 to 19.
// (RL9) Byte count from 1 to 50 accepted, exactly that many shifted.
// (RL10) Clock set to idle level before select falls and before it rises.
// (RL11) A host driving select itself puts the clock idle first.
// (RL12) Four modes: A pol0 ph0, B pol0 ph1, C pol1 ph0, D pol1 ph1.
// (RL13) Phase 1 samples on edge toward idle; phase 0 on edge away.
// (RL14) Clock rests at the polarity level whenever no bit shifts.
// (RL15) Full duplex: one byte captured for each byte sent, all returned.
// (RL16) Mode taken from the two low option bits, 0..3 giving A..D.
// (RL17) Answer gives error code, bytes transferred, received bytes padded even.
`ifndef SPI_MASTER_TRANSFER_REGS_VH
`define SPI_MASTER_TRANSFER_REGS_VH

// Option byte fields
`define OPT_AUTO_SELECT_BIT   3'h7
`define OPT_SKIP_DIR_BIT      3'h6
`define OPT_PHASE_BIT         3'h0
`define OPT_POLARITY_BIT      3'h1

// Limits
`define MAX_LINE_INDEX        5'h13
`define MIN_BYTE_COUNT        6'h01
`define MAX_BYTE_COUNT        6'h32
`define FULL_BYTE_BITS        4'h8

// Answer codes
`define ERR_NONE              8'h00
`define ERR_BAD_ARGUMENT      8'h01

// Timing: period = base + step * (256 - divisor), in ns
`define CLOCK_PERIOD_NS       100
`define SERIAL_BASE_PERIOD_NS 10000
`define SERIAL_STEP_PERIOD_NS 10000
`define DIVISOR_WRAP          9'h100

`endif

// [verilog/line_sync.v]
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module line_sync #(
    parameter WIDTH = 20
) (
    input  wire             i_clock,
    input  wire             i_rstn,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
        end
    end

    assign o_sync = stage2;
endmodule // line_sync

// [verilog/spi_master_transfer.v]
// Command-driven full duplex SPI master on twenty general digital lines
`timescale 1ns/1ns
`include "spi_master_transfer_regs.vh"
module spi_master_transfer #(
    parameter LINES     = 20,
    parameter MAX_BYTES = 50,
    parameter CNT_W     = 14,
    parameter HALF_BASE = `SERIAL_BASE_PERIOD_NS / (2 * `CLOCK_PERIOD_NS),
    parameter HALF_STEP = `SERIAL_STEP_PERIOD_NS / (2 * `CLOCK_PERIOD_NS)
) (
    input  wire             i_clock,
    input  wire             i_rstn,
    input  wire             i_start,
    input  wire [7:0]       i_transfer_options,
    input  wire [7:0]       i_clock_divisor_value,
    input  wire [2:0]       i_last_byte_bits,
    input  wire [4:0]       i_select_line_index,
    input  wire [4:0]       i_clock_line_index,
    input  wire [4:0]       i_input_line_index,
    input  wire [4:0]       i_output_line_index,
    input  wire [5:0]       i_transfer_byte_count,
    input  wire             i_payload_write,
    input  wire [5:0]       i_payload_addr,
    input  wire [7:0]       i_payload_data,
    input  wire [5:0]       i_read_addr,
    input  wire [LINES-1:0] i_line_in,
    output wire             o_busy,
    output reg              o_done,
    output reg  [7:0]       o_error_code,
    output reg  [5:0]       o_transferred_byte_count,
    output reg  [7:0]       o_read_data,
    output reg  [LINES-1:0] o_line_out,
    output reg  [LINES-1:0] o_line_oe_n
);
    localparam [6:0] S_IDLE   = 7'h01;
    localparam [6:0] S_SETUP  = 7'h02;
    localparam [6:0] S_SELECT = 7'h04;
    localparam [6:0] S_LEAD   = 7'h08;
    localparam [6:0] S_TRAIL  = 7'h10;
    localparam [6:0] S_END    = 7'h20;
    localparam [6:0] S_DESEL  = 7'h40;

    reg [7:0]       tx_mem [0:MAX_BYTES-1];
    reg [7:0]       rx_mem [0:MAX_BYTES-1];
    reg [6:0]       state;
    reg [CNT_W-1:0] half_len;
    reg [CNT_W-1:0] cnt;
    reg             auto_sel;
    reg             polarity;
    reg             phase;
    reg [2:0]       last_bits;
    reg [4:0]       sel_idx;
    reg [4:0]       clk_idx;
    reg [4:0]       in_idx;
    reg [4:0]       out_idx;
    reg [5:0]       byte_cnt;
    reg [5:0]       byte_idx;
    reg [3:0]       bits_left;
    reg [3:0]       bits_cur;
    reg [7:0]       tx_shift;
    reg [7:0]       rx_shift;

    wire [LINES-1:0] line_sync_val;
    wire             in_bit;
    wire [8:0]       steps;
    wire [31:0]      half_calc;
    wire             args_bad;
    wire             last_byte;
    wire [7:0]       rx_whole;
    wire [7:0]       rx_aligned;
    wire [5:0]       next_idx;
    wire [3:0]       next_bits;
    wire             rx_store;
    wire [5:0]       rx_store_addr;
    wire [7:0]       rx_store_data;

    // Every pin input is synchronised before the shifter samples it
    line_sync #(
        .WIDTH (LINES)
    ) u_line_sync (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_async (i_line_in),
        .o_sync  (line_sync_val)
    );

    assign in_bit = line_sync_val[in_idx];
    assign o_busy = (state != S_IDLE);

    // Divisor zero wraps to 256, giving zero extra steps and the fastest rate
    assign steps     = (i_clock_divisor_value == 8'h00) ? 9'h000
                     : (`DIVISOR_WRAP - {1'b0, i_clock_divisor_value}); // [RL5]
    assign half_calc = HALF_BASE + HALF_STEP * steps; // [RL5]

    // Out-of-range requests are answered at once and leave every pin alone
    assign args_bad = (i_transfer_byte_count < `MIN_BYTE_COUNT)
                   || (i_transfer_byte_count > `MAX_BYTE_COUNT)
                   || (i_select_line_index > `MAX_LINE_INDEX)
                   || (i_clock_line_index > `MAX_LINE_INDEX)
                   || (i_input_line_index > `MAX_LINE_INDEX)
                   || (i_output_line_index > `MAX_LINE_INDEX); // [RL8] [RL9]

    assign last_byte = (byte_idx == byte_cnt - 6'h01);
    assign next_idx  = byte_idx + 6'h01;
    assign next_bits = ((next_idx == byte_cnt - 6'h01) && (last_bits != 3'h0))
                     ? {1'b0, last_bits} : `FULL_BYTE_BITS; // [RL6]
    // Phase 1 takes its final bit at the trailing edge, in this same cycle
    assign rx_whole   = phase ? {rx_shift[6:0], in_bit} : rx_shift;
    assign rx_aligned = rx_whole << (`FULL_BYTE_BITS - bits_cur); // [RL7]

    // Odd counts clear one extra byte after the last one shifted
    assign rx_store      = (cnt == {CNT_W{1'b0}})
                        && (((state == S_TRAIL) && (bits_left == 4'h1)) || ((state == S_END) && byte_cnt[0]));
    assign rx_store_addr = (state == S_END) ? byte_cnt : byte_idx; // [RL17]
    assign rx_store_data = (state == S_END) ? 8'h00 : rx_aligned; // [RL7] [RL15]

    // Writes while busy would corrupt bytes still waiting to be shifted
    always @(posedge i_clock) begin
        if (i_payload_write && (state == S_IDLE) && (i_payload_addr < MAX_BYTES)) begin
            tx_mem[i_payload_addr] <= i_payload_data;
        end
    end

    // Receive memory has no reset, so its writes stay out of the reset process
    always @(posedge i_clock) begin
        if (rx_store) begin
            rx_mem[rx_store_addr] <= rx_store_data; // [RL7] [RL15] [RL17]
        end
    end

    // Bytes past the even-padded count still hold data of older commands
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_read_data <= 8'h00;
        end else if (i_read_addr < MAX_BYTES) begin
            o_read_data <= rx_mem[i_read_addr]; // [RL15]
        end else begin
            o_read_data <= 8'h00;
        end
    end

    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state                    <= S_IDLE;
            o_done                   <= 1'b0;
            o_error_code             <= `ERR_NONE;
            o_transferred_byte_count <= 6'h00;
            o_line_out               <= {LINES{1'b0}};
            // All lines start as inputs until a command claims them
            o_line_oe_n              <= {LINES{1'b1}};
            half_len                 <= {CNT_W{1'b0}};
            cnt                      <= {CNT_W{1'b0}};
            auto_sel                 <= 1'b0;
            polarity                 <= 1'b0;
            phase                    <= 1'b0;
            last_bits                <= 3'h0;
            sel_idx                  <= 5'h00;
            clk_idx                  <= 5'h00;
            in_idx                   <= 5'h00;
            out_idx                  <= 5'h00;
            byte_cnt                 <= 6'h00;
            byte_idx                 <= 6'h00;
            bits_left                <= 4'h0;
            bits_cur                 <= 4'h0;
            tx_shift                 <= 8'h00;
            rx_shift                 <= 8'h00;
        end else begin
            o_done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (i_start) begin
                        if (args_bad) begin
                            o_error_code             <= `ERR_BAD_ARGUMENT; // [RL17]
                            o_transferred_byte_count <= 6'h00; // [RL17]
                            o_done                   <= 1'b1;
                        end else begin
                            o_error_code <= `ERR_NONE;
                            auto_sel     <= i_transfer_options[`OPT_AUTO_SELECT_BIT];
                            polarity     <= i_transfer_options[`OPT_POLARITY_BIT]; // [RL12] [RL16]
                            phase        <= i_transfer_options[`OPT_PHASE_BIT]; // [RL12] [RL16]
                            last_bits    <= i_last_byte_bits;
                            sel_idx      <= i_select_line_index; // [RL8]
                            clk_idx      <= i_clock_line_index; // [RL8]
                            in_idx       <= i_input_line_index; // [RL8]
                            out_idx      <= i_output_line_index; // [RL8]
                            byte_cnt     <= i_transfer_byte_count; // [RL9]
                            byte_idx     <= 6'h00;
                            bits_cur     <= ((i_transfer_byte_count == 6'h01) && (i_last_byte_bits != 3'h0))
                                          ? {1'b0, i_last_byte_bits} : `FULL_BYTE_BITS; // [RL6]
                            bits_left    <= ((i_transfer_byte_count == 6'h01) && (i_last_byte_bits != 3'h0))
                                          ? {1'b0, i_last_byte_bits} : `FULL_BYTE_BITS; // [RL6]
                            tx_shift     <= tx_mem[0];
                            rx_shift     <= 8'h00;
                            half_len     <= half_calc[CNT_W-1:0];
                            cnt          <= half_calc[CNT_W-1:0];
                            // Clock goes idle first so the slave never sees a stray edge
                            o_line_out[i_clock_line_index] <= i_transfer_options[`OPT_POLARITY_BIT]; // [RL10] [RL14]
                            // Select starts released so its fall comes only after the clock is idle
                            if (i_transfer_options[`OPT_AUTO_SELECT_BIT]) begin
                                o_line_out[i_select_line_index] <= 1'b1; // [RL2] [RL10]
                            end
                            if (!i_transfer_options[`OPT_SKIP_DIR_BIT]) begin
                                o_line_oe_n[i_select_line_index] <= 1'b0; // [RL4]
                                o_line_oe_n[i_clock_line_index]  <= 1'b0; // [RL4]
                                o_line_oe_n[i_output_line_index] <= 1'b0; // [RL4]
                                o_line_oe_n[i_input_line_index]  <= 1'b1; // [RL4]
                            end
                            // With skip set the enables are left as they stand [RL3]
                            state <= S_SETUP;
                        end
                    end
                end
                S_SETUP: begin
                    if (cnt == {CNT_W{1'b0}}) begin
                        if (auto_sel) begin
                            o_line_out[sel_idx] <= 1'b0; // [RL2] [RL10]
                        end
                        cnt   <= half_len;
                        state <= S_SELECT;
                    end else begin
                        cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                S_SELECT: begin
                    if (cnt == {CNT_W{1'b0}}) begin
                        if (!phase) begin
                            o_line_out[out_idx] <= tx_shift[7]; // [RL13]
                        end
                        cnt   <= half_len;
                        state <= S_LEAD;
                    end else begin
                        cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                S_LEAD: begin
                    if (cnt == {CNT_W{1'b0}}) begin
                        o_line_out[clk_idx] <= ~polarity;
                        if (phase) begin
                            o_line_out[out_idx] <= tx_shift[7]; // [RL13]
                        end else begin
                            rx_shift <= {rx_shift[6:0], in_bit}; // [RL13] [RL15]
                        end
                        cnt   <= half_len;
                        state <= S_TRAIL;
                    end else begin
                        cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                S_TRAIL: begin
                    if (cnt == {CNT_W{1'b0}}) begin
                        o_line_out[clk_idx] <= polarity; // [RL14]
                        cnt <= half_len;
                        if (bits_left == 4'h1) begin
                            rx_shift <= 8'h00;
                            if (last_byte) begin
                                state <= S_END;
                            end else begin
                                byte_idx  <= next_idx;
                                bits_left <= next_bits;
                                bits_cur  <= next_bits;
                                tx_shift  <= tx_mem[next_idx];
                                if (!phase) begin
                                    o_line_out[out_idx] <= tx_mem[next_idx][7];
                                end
                                state <= S_LEAD;
                            end
                        end else begin
                            if (phase) begin
                                rx_shift <= {rx_shift[6:0], in_bit}; // [RL13] [RL15]
                            end else begin
                                o_line_out[out_idx] <= tx_shift[6];
                            end
                            tx_shift  <= {tx_shift[6:0], 1'b0};
                            bits_left <= bits_left - 4'h1;
                            state     <= S_LEAD;
                        end
                    end else begin
                        cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                S_END: begin
                    // Clock already idle; hold it a half period before select rises
                    if (cnt == {CNT_W{1'b0}}) begin
                        if (auto_sel) begin
                            o_line_out[sel_idx] <= 1'b1; // [RL2] [RL10]
                        end
                        state <= S_DESEL;
                    end else begin
                        cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                S_DESEL: begin
                    // Count and done leave together so the answer is settled when seen
                    o_transferred_byte_count <= byte_cnt; // [RL9] [RL17]
                    o_done                   <= 1'b1;
                    state                    <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // spi_master_transfer

// [testbench/spi_master_transfer_properties.sv]
// Port-level assertions for the SPI transfer block
`timescale 1ns/1ns
module spi_master_transfer_properties #(
    parameter LINES = 20
) (
    input wire             i_clock,
    input wire             i_rstn,
    input wire             i_start,
    input wire [7:0]       i_transfer_options,
    input wire [4:0]       i_select_line_index,
    input wire [4:0]       i_clock_line_index,
    input wire [4:0]       i_input_line_index,
    input wire [4:0]       i_output_line_index,
    input wire [5:0]       i_transfer_byte_count,
    input wire             o_busy,
    input wire             o_done,
    input wire [7:0]       o_error_code,
    input wire [5:0]       o_transferred_byte_count,
    input wire [LINES-1:0] o_line_out,
    input wire [LINES-1:0] o_line_oe_n
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    wire pol      = i_transfer_options[1];
    wire auto_sel = i_transfer_options[7];
    wire skip     = i_transfer_options[6];
    wire sck      = o_line_out[i_clock_line_index];
    wire sel      = o_line_out[i_select_line_index];
    wire ok_done  = o_done && o_error_code == 8'h00;
    wire bad_cnt  = i_transfer_byte_count == 6'h00 || i_transfer_byte_count > 6'h32;
    wire bad_idx  = i_select_line_index > 5'h13 || i_clock_line_index > 5'h13 ||
                    i_input_line_index > 5'h13 || i_output_line_index > 5'h13;
    done_pulse_a: assert property (o_done |=> !o_done) else $error("done longer than a cycle");
    start_taken_a: assert property (i_start && !o_busy |=> o_busy || o_done) else $error("start lost");
    bad_count_a: assert property (i_start && !o_busy && bad_cnt |=> o_done && o_error_code == 8'h01
        && o_transferred_byte_count == 6'h00) else $error("bad count accepted");
    bad_index_a: assert property (i_start && !o_busy && bad_idx |=> o_done && o_error_code == 8'h01)
        else $error("bad index accepted");
    good_count_a: assert property (ok_done |-> o_transferred_byte_count == i_transfer_byte_count)
        else $error("wrong byte count");
    busy_hold_a: assert property ($fell(o_busy) |-> o_done) else $error("busy dropped early");
    idle_clock_a: assert property (ok_done |-> sck == pol) else $error("clock not idle at end");
    select_fall_a: assert property (o_busy && $fell(sel) |-> sck == pol) else $error("clock not idle");
    select_rise_a: assert property (o_busy && $rose(sel) |-> sck == pol) else $error("clock not idle");
    select_done_a: assert property (ok_done && auto_sel |-> sel) else $error("select still low");
    dir_set_a: assert property (ok_done && !skip |-> !o_line_oe_n[i_select_line_index] &&
        !o_line_oe_n[i_clock_line_index] && !o_line_oe_n[i_output_line_index] &&
        o_line_oe_n[i_input_line_index]) else $error("line directions wrong");
    dir_keep_a: assert property ((o_busy || i_start) && skip |=> $stable(o_line_oe_n))
        else $error("directions moved");
    cover property (ok_done && auto_sel && pol);
    cover property (o_done && o_error_code == 8'h01);
    cover property (o_busy && skip);
endmodule // spi_master_transfer_properties

bind spi_master_transfer spi_master_transfer_properties #(.LINES(LINES)) u_props (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_start(i_start), .i_transfer_options(i_transfer_options),
    .i_select_line_index(i_select_line_index), .i_clock_line_index(i_clock_line_index),
    .i_input_line_index(i_input_line_index), .i_output_line_index(i_output_line_index),
    .i_transfer_byte_count(i_transfer_byte_count), .o_busy(o_busy), .o_done(o_done),
    .o_error_code(o_error_code), .o_transferred_byte_count(o_transferred_byte_count),
    .o_line_out(o_line_out), .o_line_oe_n(o_line_oe_n));

// [testbench/spi_slave_model.sv]
// Behavioural SPI slave: returns stored bytes and records bits it receives
`timescale 1ns/1ns
module spi_slave_model (
    input  wire  i_clock,
    input  wire  i_active,
    input  wire  i_sclk,
    input  wire  i_mosi,
    input  wire  i_cpol,
    input  wire  i_cpha,
    output logic o_miso
);
    logic [7:0] mem [0:49];
    bit         got [$];
    logic       prev = 1'b0;
    logic       armed = 1'b0;
    logic       junk = 1'b0;
    int         k = 0;
    // Setup move to idle level is not a data edge, so wait for the first lead
    wire        edge_ok = i_active && i_sclk !== prev && (armed || i_sclk !== i_cpol);
    wire        shift = edge_ok && ((i_sclk === i_cpol) != i_cpha);
    always @(posedge i_clock) begin
        prev <= i_sclk;
        junk <= ~junk;
        armed <= i_active && (armed || edge_ok);
        if (!i_active)
            k <= i_cpha ? -1 : 0;
        else if (shift)
            k <= k + 1;
        if (edge_ok && !shift)
            got.push_back(i_mosi);
    end
    // Outside a transfer the line toggles so stale data never passes
    assign o_miso = (i_active && k >= 0 && k < 400) ? mem[k / 8][7 - k % 8] : junk;
endmodule // spi_slave_model

// [testbench/tb_spi_master_transfer.sv]
// Self-checking bench for the SPI transfer block with a slave model
`timescale 1ns/1ns
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH %0t %s", $time, m); end end
module tb_spi_master_transfer;
    localparam HB = 4;
    localparam HS = 1;
    logic        i_clock = 1'b0, i_rstn = 1'b0, i_start = 1'b0, pwr = 1'b0, lead = 1'b0, psck = 1'b0;
    logic [7:0]  opts = 8'h80, div = 8'h00, pdata = 8'h00;
    logic [2:0]  nbits = 3'h0;
    logic [4:0]  sel_i = 5'h00, ck_i = 5'h01, mi_i = 5'h02, mo_i = 5'h13;
    logic [5:0]  cnt = 6'h01, paddr = 6'h00, raddr = 6'h00;
    logic [19:0] line_in;
    logic [31:0] v;
    logic [7:0]  tx [0:49];
    wire         busy, done, miso;
    wire [7:0]   err, rdata;
    wire [5:0]   xcnt;
    wire [19:0]  lout, loe_n;
    int          n_errors = 0, n_checks = 0, seed = 57, gap = 0, r;
    spi_master_transfer #(.HALF_BASE(HB), .HALF_STEP(HS)) dut (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_start(i_start), .i_transfer_options(opts),
        .i_clock_divisor_value(div), .i_last_byte_bits(nbits), .i_select_line_index(sel_i),
        .i_clock_line_index(ck_i), .i_input_line_index(mi_i), .i_output_line_index(mo_i),
        .i_transfer_byte_count(cnt), .i_payload_write(pwr), .i_payload_addr(paddr),
        .i_payload_data(pdata), .i_read_addr(raddr), .i_line_in(line_in), .o_busy(busy),
        .o_done(done), .o_error_code(err), .o_transferred_byte_count(xcnt), .o_read_data(rdata),
        .o_line_out(lout), .o_line_oe_n(loe_n));
    spi_slave_model slave (.i_clock(i_clock), .i_active(busy), .i_sclk(lout[ck_i]), .i_mosi(lout[mo_i]),
        .i_cpol(opts[1]), .i_cpha(opts[0]), .o_miso(miso));
    always @* begin
        line_in = lout;
        line_in[mi_i] = miso;
    end
    // Trail phase length from lead edge to trail edge gives the rate
    always @(posedge i_clock) begin
        gap <= gap + 1;
        psck <= lout[ck_i];
        if (!busy)
            lead <= 1'b0;
        if (busy && lout[ck_i] !== psck) begin
            gap <= 1;
            if (lout[ck_i] !== opts[1])
                lead <= 1'b1;
            else if (lead)
                `CHK(gap, HB + HS * ((256 - int'(div)) % 256) + 1, "serial rate")
        end
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic transfer(input logic [7:0] o, d, input logic [2:0] nb, input logic [5:0] n,
                            input logic [4:0] s, c, i, m);
        int t, j, nl;
        logic [7:0] want;
        bit q [$];
        bit bad;
        while (busy)
            @(negedge i_clock);
        bad = n < 1 || n > 50 || s > 19 || c > 19 || i > 19 || m > 19;
        {opts, div, nbits, cnt, sel_i, ck_i, mi_i, mo_i} = {o, d, nb, n, s, c, i, m};
        for (t = 0; t < 50; t++) begin // Full fill pads odd counts
            tx[t] = 8'($random(seed));
            slave.mem[t] = 8'($random(seed));
            {pwr, paddr, pdata} = {1'b1, 6'(t), tx[t]};
            @(negedge i_clock);
        end
        pwr = 1'b0;
        slave.got.delete();
        i_start = 1'b1;
        @(negedge i_clock);
        i_start = !bad;
        // A second start and a payload write while busy are both refused
        {pwr, paddr, pdata} = {!bad, n - 6'h01, ~tx[n - 6'h01]};
        @(negedge i_clock);
        {i_start, pwr} = 2'b00;
        for (t = 0; t < 30000 && done !== 1'b1 && !bad; t++)
            @(negedge i_clock);
        `CHK(done | bad, 1'b1, "done pulse")
        `CHK(err, bad ? 8'h01 : 8'h00, "error code")
        `CHK(xcnt, bad ? 6'h00 : n, "byte count")
        nl = (nb == 0) ? 8 : int'(nb);
        for (t = 0; t < n && !bad; t++)
            for (j = 0; j < ((t == n - 1) ? nl : 8); j++)
                q.push_back(tx[t][7 - j]);
        `CHK(slave.got.size(), bad ? 0 : q.size(), "bit count")
        j = 0;
        for (t = 0; t < q.size(); t++)
            if (t >= slave.got.size() || slave.got[t] !== q[t])
                j++;
        `CHK(j, 0, "sent bits")
        for (t = 0; t < n + n % 2 && !bad; t++) begin
            raddr = 6'(t);
            @(negedge i_clock);
            want = (t == n) ? 8'h00 : (t == n - 1) ? slave.mem[t] & ~(8'hff >> nl) : slave.mem[t];
            `CHK(rdata, want, "received byte")
        end
        $display("test done options %h count %0d", o, n);
    endtask
    initial begin
        forever #50 i_clock = ~i_clock;
    end
    initial begin
        #9000000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(negedge i_clock);
        i_rstn = 1'b1;
        for (r = 0; r < 4; r++)
            transfer({6'h20, r[1:0]}, 8'(8'h00 - r), 3'(2 * r + 1), 6'(r + 1), 5'(4 * r), 5'(4 * r + 1),
                     5'(4 * r + 2), 5'(19 - r));
        for (r = 0; r < 4; r++) begin
            v = $random(seed);
            transfer({v[7], 5'h00, v[1:0]}, {5'h1f, v[4:2]}, v[10:8], 6'(1 + v[15:11]), 5'h00, 5'h01,
                     5'h02, 5'h13);
        end
        transfer(8'h83, 8'h00, 3'h0, 6'h32, 5'h00, 5'h01, 5'h02, 5'h13);
        transfer(8'hc1, 8'h00, 3'h5, 6'h05, 5'h03, 5'h07, 5'h0b, 5'h0f);
        `CHK({loe_n[3], loe_n[7], loe_n[11], loe_n[15]}, 4'hf, "skip direction")
        transfer(8'h80, 8'h00, 3'h0, 6'h00, 5'h00, 5'h01, 5'h02, 5'h13);
        transfer(8'h80, 8'h00, 3'h0, 6'h33, 5'h00, 5'h01, 5'h02, 5'h13);
        transfer(8'h80, 8'h00, 3'h0, 6'h02, 5'h00, 5'h14, 5'h02, 5'h13);
        report_and_stop();
    end
endmodule // tb_spi_master_transfer
